// ---- hdl/rgs_params.svh ----
// Register indices, field positions, reset values and timing counts
`ifndef RGS_PARAMS_SVH
`define RGS_PARAMS_SVH
// Register indices; byte address is four times the index
`define RGS_IDX_SETUP7    12'h113
`define RGS_IDX_RESULT    12'h312
`define RGS_IDX_CONV_HI   12'h327
`define RGS_IDX_CONV_LO   12'h328
`define RGS_IDX_DWELL     12'h32F
`define RGS_IDX_OVERRIDE  12'h35D
`define RGS_IDX_RAISE     12'h35E
`define RGS_IDX_DROP      12'h35F
`define RGS_IDX_GAINST    12'h360
`define RGS_IDX_COMMAND   12'h3F0
// Field positions
`define RGS_POLICY_LSB    0
`define RGS_HOLD_BIT      6
`define RGS_OVR_LNA_LSB   0
`define RGS_OVR_MIX_BIT   2
`define RGS_OVR_FILT_LSB  3
// Reset values
`define RGS_DWELL_RST     8'h28
`define RGS_RAISE_RST     8'h40
`define RGS_DROP_RST      8'hC0
// Stage gain codes read back in the gain state register
`define RGS_CODE_S1       8'h00
`define RGS_CODE_S2       8'h01
`define RGS_CODE_S3       8'h02
`define RGS_CODE_S4       8'h0A
`define RGS_CODE_S5       8'h12
`define RGS_CODE_S6       8'h16
// One divider unit of dwell: 25 us over 40 units
`define RGS_TICK_NS       625
`define RGS_CLK_NS        8
`define RGS_TICK_CYC      (`RGS_TICK_NS / `RGS_CLK_NS)
`endif

// ---- hdl/rgs_pkg.sv ----
// Types shared by the gain and signal level block
package rgs_pkg;
   typedef enum logic [1:0] {
      POL_FREE   = 2'b00,
      POL_MANUAL = 2'b01,
      POL_HOLD   = 2'b10,
      POL_LOCK   = 2'b11
   } rgs_policy_type;
   typedef enum logic [1:0] {
      GAIN_HIGH = 2'b00,
      GAIN_MED  = 2'b01,
      GAIN_LOW  = 2'b10
   } rgs_level_type;
endpackage : rgs_pkg

// ---- hdl/rgs_top.sv ----
// Receive gain controller and signal level readout with APB registers
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps
`include "rgs_params.svh"
module rgs_top (
   input  wire logic       pclk,          // Bus and loop clock
   input  wire logic       presetn,       // Async reset, low
   input  wire logic       clk_en,        // Freezes all state when low
   input  wire logic [13:0] paddr,        // APB byte address
   input  wire logic       psel,          // APB select
   input  wire logic       penable,       // APB access phase
   input  wire logic       pwrite,        // APB write
   input  wire logic [31:0] pwdata,       // APB write data
   output logic      [31:0] prdata,       // APB read data
   output logic            pready,        // APB ready
   output logic            pslverr,       // APB error, unmapped
   input  wire logic [7:0] level_code,    // Converter level pin
   input  wire logic       preamble_hit,  // Preamble detected pin
   input  wire logic       packet_ok,     // Valid packet end pin
   input  wire logic       packet_mode,   // High packet, low sport
   input  wire logic       rx_state,      // Receive state pin
   input  wire logic       on_state,      // Idle on state pin
   output logic      [1:0] lna_gain,      // Amplifier gain level
   output logic            mix_gain_low,  // Mixer gain low
   output logic      [1:0] filt_gain      // Filter gain level
);
   // ==========================================================
   // Functions
   function automatic logic [7:0] stage_code(input logic [2:0] s);
      case (s)
         3'd1:    stage_code = `RGS_CODE_S1;
         3'd2:    stage_code = `RGS_CODE_S2;
         3'd3:    stage_code = `RGS_CODE_S3;
         3'd4:    stage_code = `RGS_CODE_S4;
         3'd5:    stage_code = `RGS_CODE_S5;
         default: stage_code = `RGS_CODE_S6;
      endcase
   endfunction : stage_code

   function automatic logic [4:0] stage_gains(input logic [2:0] s);
      // {lna[1:0], mixer low, filter[1:0]}
      case (s)
         3'd1:    stage_gains = {rgs_pkg::GAIN_HIGH, 1'b0, rgs_pkg::GAIN_HIGH};
         3'd2:    stage_gains = {rgs_pkg::GAIN_HIGH, 1'b1, rgs_pkg::GAIN_HIGH};
         3'd3:    stage_gains = {rgs_pkg::GAIN_MED,  1'b1, rgs_pkg::GAIN_HIGH};
         3'd4:    stage_gains = {rgs_pkg::GAIN_LOW,  1'b1, rgs_pkg::GAIN_HIGH};
         3'd5:    stage_gains = {rgs_pkg::GAIN_LOW,  1'b1, rgs_pkg::GAIN_MED};
         default: stage_gains = {rgs_pkg::GAIN_LOW,  1'b1, rgs_pkg::GAIN_LOW};
      endcase
   endfunction : stage_gains

   // ==========================================================
   // Pin synchronisers
   logic [7:0] lvl_s1_r, lvl_r;
   logic [4:0] pin_s1_r, pin_r;
   logic       pkt_prev_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lvl_s1_r   <= 8'h00;
         lvl_r      <= 8'h00;
         pin_s1_r   <= 5'h00;
         pin_r      <= 5'h00;
         pkt_prev_r <= 1'b0;
      end else if (clk_en) begin
         lvl_s1_r   <= level_code;
         lvl_r      <= lvl_s1_r;
         pin_s1_r   <= {preamble_hit, packet_ok, packet_mode, rx_state, on_state};
         pin_r      <= pin_s1_r;
         pkt_prev_r <= pin_r[3];
      end
   end
   logic pre_hit, pkt_pulse, pkt_mode, in_rx, in_on;
   assign pre_hit   = pin_r[4];
   assign pkt_pulse = pin_r[3] & ~pkt_prev_r;
   assign pkt_mode  = pin_r[2];
   assign in_rx     = pin_r[1];
   assign in_on     = pin_r[0];

   // ==========================================================
   // Registers
   logic [7:0] setup7_r, dwell_div_r, override_r, raise_r, drop_r;
   logic [7:0] result_r, gainst_r;
   logic [2:0] stage_r;
   logic       meas_cmd;
   logic [11:0] idx;
   logic        setup_ph, wr_acc;
   assign idx      = paddr[13:2];
   assign setup_ph = psel & ~penable;
   assign wr_acc   = psel & penable & pready & pwrite;
   assign meas_cmd = wr_acc && idx == `RGS_IDX_COMMAND;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setup7_r    <= 8'h00;
         dwell_div_r <= `RGS_DWELL_RST;
         override_r  <= 8'h00;
         raise_r     <= `RGS_RAISE_RST;
         drop_r      <= `RGS_DROP_RST;
      end else if (clk_en && wr_acc) begin
         case (idx)
            `RGS_IDX_SETUP7:   setup7_r    <= pwdata[7:0];
            `RGS_IDX_DWELL:    dwell_div_r <= pwdata[7:0];
            `RGS_IDX_OVERRIDE: override_r  <= pwdata[7:0];
            `RGS_IDX_RAISE:    raise_r     <= pwdata[7:0];
            `RGS_IDX_DROP:     drop_r      <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Read mux, captured in setup so the access phase has no wait
   logic [7:0] rd_nxt;
   logic       err_nxt;
   always_comb begin
      rd_nxt  = 8'h00;
      err_nxt = 1'b0;
      case (idx)
         `RGS_IDX_SETUP7:   rd_nxt = setup7_r;
         `RGS_IDX_RESULT:   rd_nxt = result_r;
         `RGS_IDX_CONV_HI:  rd_nxt = lvl_r;
         `RGS_IDX_CONV_LO:  rd_nxt = 8'h00;
         `RGS_IDX_DWELL:    rd_nxt = dwell_div_r;
         `RGS_IDX_OVERRIDE: rd_nxt = override_r;
         `RGS_IDX_RAISE:    rd_nxt = raise_r;
         `RGS_IDX_DROP:     rd_nxt = drop_r;
         `RGS_IDX_GAINST:   rd_nxt = gainst_r;
         `RGS_IDX_COMMAND:  rd_nxt = 8'h00;
         default:           err_nxt = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= setup_ph;
         pslverr <= setup_ph & err_nxt;
         if (setup_ph) begin
            prdata <= {24'h00_0000, rd_nxt};
         end
      end
   end

   // ==========================================================
   // Dwell timing
   logic [6:0] pre_r;
   logic [7:0] dwell_r;
   logic       tick, dwell_end;
   assign tick      = pre_r == 7'(`RGS_TICK_CYC - 1);
   assign dwell_end = tick && dwell_r >= dwell_div_r - 8'h01;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r   <= 7'h00;
         dwell_r <= 8'h00;
      end else if (clk_en) begin
         pre_r <= tick ? 7'h00 : pre_r + 7'h01;
         if (dwell_end) begin
            dwell_r <= 8'h00;
         end else if (tick) begin
            dwell_r <= dwell_r + 8'h01;
         end
      end
   end

   // ==========================================================
   // Gain loop
   rgs_pkg::rgs_policy_type policy;
   logic locked_r, frozen;
   assign policy = rgs_pkg::rgs_policy_type'(setup7_r[`RGS_POLICY_LSB +: 2]);
   // Hold bit covers host reads while gain would otherwise move
   assign frozen = policy == rgs_pkg::POL_HOLD || override_r[`RGS_HOLD_BIT] ||
                   (policy == rgs_pkg::POL_LOCK && locked_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         locked_r <= 1'b0;
      end else if (clk_en) begin
         if (!in_rx || policy != rgs_pkg::POL_LOCK) begin
            locked_r <= 1'b0;
         end else if (pre_hit) begin
            locked_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_r <= 3'd1;
      end else if (clk_en && dwell_end && policy != rgs_pkg::POL_MANUAL && !frozen) begin
         if (lvl_r > drop_r && stage_r < 3'd6) begin
            stage_r <= stage_r + 3'd1;
         end else if (lvl_r < raise_r && stage_r > 3'd1) begin
            stage_r <= stage_r - 3'd1;
         end
      end
   end

   logic [4:0] gains_nxt;
   always_comb begin
      if (policy == rgs_pkg::POL_MANUAL) begin
         gains_nxt = {override_r[`RGS_OVR_LNA_LSB +: 2], override_r[`RGS_OVR_MIX_BIT],
                      override_r[`RGS_OVR_FILT_LSB +: 2]};
      end else begin
         gains_nxt = stage_gains(stage_r);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lna_gain     <= 2'b00;
         mix_gain_low <= 1'b0;
         filt_gain    <= 2'b00;
         gainst_r     <= 8'h00;
      end else if (clk_en) begin
         lna_gain     <= gains_nxt[4:3];
         mix_gain_low <= gains_nxt[2];
         filt_gain    <= gains_nxt[1:0];
         gainst_r     <= policy == rgs_pkg::POL_MANUAL ?
                         {3'b000, override_r[4:0]} : stage_code(stage_r);
      end
   end

   // ==========================================================
   // Signal level result
   // Running average over about eight samples for the measure command
   logic [10:0] acc_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_r <= 11'h000;
      end else if (clk_en) begin
         acc_r <= acc_r - {3'b000, acc_r[10:3]} + {3'b000, lvl_r};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_r <= 8'h00;
      end else if (clk_en) begin
         if (meas_cmd && in_on) begin
            result_r <= acc_r[10:3];
         end else if (pkt_pulse && pkt_mode) begin
            result_r <= lvl_r;
         end
      end
   end

   // ==========================================================
   // Checks
   a_stage_range: assert property (@(posedge pclk) disable iff (!presetn)
      stage_r >= 3'd1 && stage_r <= 3'd6) else $error("stage out of range");
   a_drop_step: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && dwell_end && policy == rgs_pkg::POL_FREE && !override_r[6] &&
      lvl_r > drop_r && stage_r < 3'd6 |=> stage_r == $past(stage_r) + 3'd1)
      else $error("gain not lowered");
   a_raise_step: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && dwell_end && policy == rgs_pkg::POL_FREE && !override_r[6] &&
      lvl_r < raise_r && lvl_r <= drop_r && stage_r > 3'd1 |=>
      stage_r == $past(stage_r) - 3'd1) else $error("gain not raised");
   a_hold_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      frozen |=> $stable(stage_r)) else $error("stage moved while held");
   a_step_once: assert property (@(posedge pclk) disable iff (!presetn)
      $changed(stage_r) |=> !$changed(stage_r)) else $error("two steps");
   a_stage_one: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && stage_r == 3'd1 && policy != rgs_pkg::POL_MANUAL |=>
      lna_gain == 2'b00 && !mix_gain_low && filt_gain == 2'b00)
      else $error("stage one gains wrong");
   a_gain_readout: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && policy == rgs_pkg::POL_FREE |=> gainst_r == stage_code($past(stage_r)))
      else $error("gain state wrong");
   a_auto_store: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && pkt_pulse && pkt_mode && !meas_cmd |=> result_r == $past(lvl_r))
      else $error("packet level not stored");
   a_sport_noauto: assert property (@(posedge pclk) disable iff (!presetn)
      !pkt_mode && !meas_cmd |=> $stable(result_r)) else $error("sport mode store");
   a_cmd_store: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && meas_cmd && in_on |=> result_r == $past(acc_r[10:3]))
      else $error("measure not stored");
   a_conv_readback: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && setup_ph && idx == `RGS_IDX_CONV_HI |=> prdata[7:0] == $past(lvl_r))
      else $error("converter readback wrong");
   a_manual_gains: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && policy == rgs_pkg::POL_MANUAL |=>
      lna_gain == $past(override_r[1:0]) && mix_gain_low == $past(override_r[2]) &&
      filt_gain == $past(override_r[4:3])) else $error("manual gains not applied");
endmodule : rgs_top

// ---- verif/rgs_front_model.sv ----
// Receive front end model: converter code and packet end pulse
`timescale 1ns/10ps
module rgs_front_model (
   input  wire logic       pclk,       // Clock
   input  wire logic       presetn,    // Async reset, low
   input  wire logic [7:0] lvl_set,    // Level the front end reports
   input  wire logic       pkt_req,    // One cycle: packet received
   output logic      [7:0] level_code, // Converter code pin
   output logic            packet_ok   // Valid packet end pin
);
   logic [2:0] pulse_r;
   // Converter code changes only on clock edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) level_code <= 8'h00;
      else level_code <= lvl_set;
   end
   // Stretched pulse so the pin synchronizer cannot miss it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pulse_r <= 3'h0;
      else if (pkt_req) pulse_r <= 3'h4;
      else if (pulse_r != 3'h0) pulse_r <= pulse_r - 3'h1;
   end
   assign packet_ok = (pulse_r != 3'h0);
endmodule : rgs_front_model

// ---- verif/tb_top.sv ----
// Testbench for the gain and signal level block
`timescale 1ns/10ps
`include "rgs_params.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pkt_req, pre, rx, on, pm, ce;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, mix;
   logic [7:0] lvl, code;
   logic [1:0] lna, filt;
   wire  [7:0] lvl_pin;
   wire        pkt_pin;
   wire  [4:0] gout = {filt, mix, lna};
   logic [4:0] tbl [6] = '{5'h00, 5'h04, 5'h05, 5'h06, 5'h0E, 5'h16};
   logic [7:0] codes [6] = '{8'h00, 8'h01, 8'h02, 8'h0A, 8'h12, 8'h16};
   int mismatches, checks, n, s;
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   rgs_top dut_u (.pclk(pclk), .presetn(presetn), .clk_en(ce), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .level_code(lvl_pin),
      .preamble_hit(pre), .packet_ok(pkt_pin), .packet_mode(pm), .rx_state(rx),
      .on_state(on), .lna_gain(lna), .mix_gain_low(mix), .filt_gain(filt));
   rgs_front_model fe_u (.pclk(pclk), .presetn(presetn), .lvl_set(lvl),
      .pkt_req(pkt_req), .level_code(lvl_pin), .packet_ok(pkt_pin));
   // ==========================================
   // Bus tasks
   task apb(input logic [11:0] idx, input logic wr, input logic [7:0] wd);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= {idx, 2'b00};
      pwrite <= wr;
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) `CHK(1'b0, 1'b1)
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rdchk(input logic [11:0] idx, input logic [7:0] e);
      apb(idx, 1'b0, 8'h00);
      `CHK(rd, {24'h0, e})
   endtask : rdchk
   // Waits for the gain outputs to move, n = cycles waited
   task wait_gain(input logic [4:0] e);
      logic [4:0] prev;
      prev = gout;
      n = 0;
      while (gout === prev && n < 4000) begin
         @(posedge pclk);
         n++;
      end
      `CHK(gout, e)
   endtask : wait_gain
   // Host side input power estimate from gain state and converter code
   function automatic int host_dbm(input logic [7:0] conv, input logic [7:0] gst);
      int corr;
      case (gst)
         8'h00: corr = 44;
         8'h01: corr = 35;
         8'h02: corr = 26;
         8'h0A: corr = 17;
         8'h12: corr = 10;
         default: corr = 0;
      endcase
      return int'(conv) / 7 + corr - 109;
   endfunction : host_dbm
   task tally_and_finish;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   initial begin
      #200000;
      mismatches++;
      tally_and_finish;
   end
   // ==========================================
   // Tests
   initial begin
      {presetn, psel, penable, pwrite, pkt_req, pre, rx, on, pm} = '0;
      ce = 1'b1;
      paddr = '0;
      pwdata = '0;
      lvl = 8'h77;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(`RGS_IDX_DWELL, `RGS_DWELL_RST);
      rdchk(`RGS_IDX_SETUP7, 8'h00);
      rdchk(`RGS_IDX_GAINST, codes[0]);
      rdchk(`RGS_IDX_CONV_LO, 8'h00);
      rdchk(12'h0AA, 8'h00);
      `CHK(err, 1'b1)
      rdchk(`RGS_IDX_CONV_HI, 8'h77);
      // Strong signal walks gain down, one stage per dwell
      apb(`RGS_IDX_DWELL, 1'b1, 8'h02);
      lvl <= 8'hFF;
      for (s = 1; s < 6; s++) begin
         wait_gain(tbl[s]);
         if (s > 1) `CHK(n, 2 * `RGS_TICK_CYC)
      end
      rdchk(`RGS_IDX_GAINST, codes[5]);
      repeat (400) @(posedge pclk);
      `CHK(gout, tbl[5])
      // Host hold, read, resume
      apb(`RGS_IDX_OVERRIDE, 1'b1, 8'h40);
      lvl <= 8'h23;
      repeat (400) @(posedge pclk);
      `CHK(gout, tbl[5])
      rdchk(`RGS_IDX_GAINST, codes[5]);
      code = rd[7:0];
      rdchk(`RGS_IDX_CONV_HI, 8'h23);
      `CHK(host_dbm(rd[7:0], code), -104)
      apb(`RGS_IDX_OVERRIDE, 1'b1, 8'h00);
      // Clock enable low must freeze the loop although the level asks to step
      ce <= 1'b0;
      repeat (400) @(posedge pclk);
      `CHK(gout, tbl[5])
      ce <= 1'b1;
      for (s = 4; s >= 0; s--) wait_gain(tbl[s]);
      repeat (400) @(posedge pclk);
      `CHK(gout, tbl[0])
      // Hold policy, then preamble lock and its release
      apb(`RGS_IDX_SETUP7, 1'b1, 8'h02);
      lvl <= 8'hFF;
      repeat (400) @(posedge pclk);
      `CHK(gout, tbl[0])
      // Neutral level while the policy switches, lock lands one cycle late
      lvl <= 8'h77;
      rx <= 1'b1;
      pre <= 1'b1;
      apb(`RGS_IDX_SETUP7, 1'b1, 8'h03);
      lvl <= 8'hFF;
      repeat (400) @(posedge pclk);
      `CHK(gout, tbl[0])
      rx <= 1'b0;
      wait_gain(tbl[1]);
      // Manual gains written by the host
      apb(`RGS_IDX_SETUP7, 1'b1, 8'h01);
      apb(`RGS_IDX_OVERRIDE, 1'b1, 8'h15);
      repeat (10) @(posedge pclk);
      `CHK(gout, 5'h15)
      rdchk(`RGS_IDX_GAINST, 8'h15);
      apb(`RGS_IDX_SETUP7, 1'b1, 8'h00);
      apb(`RGS_IDX_OVERRIDE, 1'b1, 8'h00);
      // End of packet store, packet mode only
      pm <= 1'b1;
      lvl <= 8'h9C;
      repeat (10) @(posedge pclk);
      pkt_req <= 1'b1;
      @(posedge pclk);
      pkt_req <= 1'b0;
      repeat (12) @(posedge pclk);
      rdchk(`RGS_IDX_RESULT, 8'h9C);
      pm <= 1'b0;
      lvl <= 8'h33;
      repeat (10) @(posedge pclk);
      pkt_req <= 1'b1;
      @(posedge pclk);
      pkt_req <= 1'b0;
      repeat (12) @(posedge pclk);
      rdchk(`RGS_IDX_RESULT, 8'h9C);
      // Measure command counts only in the on state
      lvl <= 8'h20;
      repeat (300) @(posedge pclk);
      apb(`RGS_IDX_COMMAND, 1'b1, 8'h01);
      rdchk(`RGS_IDX_RESULT, 8'h9C);
      on <= 1'b1;
      apb(`RGS_IDX_COMMAND, 1'b1, 8'h01);
      rdchk(`RGS_IDX_RESULT, 8'h20);
      tally_and_finish;
   end
endmodule : tb_top
